// ---- core/lpp_chain.sv ----
`timescale 1ns/1ps
`include "lpp_defs.svh"
module lpp_chain #(
   parameter int COLS = 4096,  // pixels per sensor line
   parameter int NSETS = 4,  // coefficient and table banks
   parameter bit COLOR = 1'b0,  // colour sensor build
   parameter bit SUPER_RES = 1'b0  // super_resolution_variant build
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic in_valid,
   input wire logic in_sol,
   input wire logic [11:0] in_data,
   output logic out_valid,
   output logic out_sol,
   output logic [11:0] out_data
);
   localparam int COLW = $clog2(COLS);
   localparam int SETW = $clog2(NSETS);

   // software visible state
   logic [31:0] ctrl;  // mode bits
   logic signed [12:0] black;  // black level in dn
   logic [15:0] gain_r, gain_g, gain_b;  // 8.8 digital gains
   logic [18:0] ffc_addr;  // coefficient pointer
   logic [11:0] lut_addr;  // table pointer
   logic [15:0] lut_cmd;  // fill command and strength
   logic [15:0] frame_lines;  // virtual frame height before binning

   // memories
   logic [15:0] ffc_off [NSETS][COLS];  // per column offset
   logic [15:0] ffc_gain [NSETS][COLS];  // per column gain, 4.12
   logic [11:0] lut_mem [NSETS][4096];  // one table per config set
   logic [15:0] vbuf [COLS];  // partial vertical sums

   // fill engine
   lpp_pkg::lpp_fill_state_t fill_state;
   logic [11:0] fill_idx;  // entry being written
   logic fill_gamma;  // curve rather than neutral
   lpp_pkg::lpp_pix_t fill_val;  // entry value

   // bus decode helpers
   logic wr_go;  // write takes effect this edge
   logic [31:0] wmerge;  // byte merged write word

   // pixel pipe
   logic [COLW-1:0] col_cnt, cur_col;
   logic line_par, cur_par;
   logic a_valid, a_sol, a_par;
   logic [11:0] a_pix;
   logic [COLW-1:0] a_col;
   logic [15:0] a_off, a_gain, dgain_sel;
   logic b_valid, b_sol;
   logic [11:0] b_pix;
   logic [COLW-1:0] b_col;
   logic [1:0] hsh, vsh, hlast, vlast, hcnt, vline, cur_h, cur_v;
   logic [13:0] hacc, hsum;
   logic [15:0] vsum;
   logic [COLW-1:0] bcol;
   logic sol_pend, emit;
   logic e_valid, e_sol;
   logic [15:0] e_sum;
   lpp_pkg::lpp_pix_t e_pix;

   // field views
   wire ffc_en = ctrl[`LPP_CTRL_FFC_EN];
   wire out8 = ctrl[`LPP_CTRL_OUT8];
   wire bin_sum = ctrl[`LPP_CTRL_BIN_SUM];
   wire [SETW-1:0] ffc_set = ctrl[`LPP_CTRL_FFC_SET];
   wire [SETW-1:0] cfg_set = ctrl[`LPP_CTRL_CFG_SET];
   // R13 the table path is absent on super resolution
   wire lut_on = ctrl[`LPP_CTRL_LUT_EN] && !SUPER_RES;
   wire fill_busy = fill_state == lpp_pkg::LPP_FILL_RUN;

   // byte lane merge of a write into an old word
   function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // bin factor code to shift; code 3 is treated as off
   function automatic logic [1:0] bin_shift(input logic [1:0] code);
      if (code == 2'h1 || code == 2'h2) begin
         return code;
      end
      return 2'h0;
   endfunction : bin_shift

   // bowed curve: positive strength lifts lows (gamma below unity),
   // negative strength pulls them down (gamma above unity)
   function automatic lpp_pkg::lpp_pix_t gamma_entry(input logic [11:0] x,
      input logic signed [7:0] k);
      logic [23:0] bow;
      logic signed [33:0] lift;
      bow = x * (`LPP_PIX_MAX - x);
      lift = $signed({{10{1'b0}}, bow}) * $signed({{26{k[7]}}, k});
      lift = lift >>> `LPP_GAMMA_SHIFT;
      return lpp_pkg::lpp_sat12($signed({{22{1'b0}}, x}) + lift);
   endfunction : gamma_entry

   // read decode; table and coefficient data ports read as zero
   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      if (a == `LPP_REG_CTRL) begin
         return ctrl;
      end else if (a == `LPP_REG_BLACK) begin
         return {{19{1'b0}}, black};
      end else if (a == `LPP_REG_GAIN_R) begin
         return {16'h0000, gain_r};
      end else if (a == `LPP_REG_GAIN_G) begin
         return {16'h0000, gain_g};
      end else if (a == `LPP_REG_GAIN_B) begin
         return {16'h0000, gain_b};
      end else if (a == `LPP_REG_FFC_ADDR) begin
         return {13'h0000, ffc_addr};
      end else if (a == `LPP_REG_LUT_ADDR) begin
         return {20'h0_0000, lut_addr};
      end else if (a == `LPP_REG_LUT_CMD) begin
         return {16'h0000, lut_cmd};
      end else if (a == `LPP_REG_STATUS) begin
         return {29'h0000_0000, 1'(COLOR), 1'(SUPER_RES), fill_busy};
      end else if (a == `LPP_REG_FRAME) begin
         return {16'h0000, frame_lines};
      end else if (a == `LPP_REG_BINNED) begin
         // R04 reported height shrinks with vertical binning
         return {16'h0000, frame_lines >> vsh};
      end
      return 32'h0000_0000;
   endfunction : rd_mux

   assign wr_go = avs_write && !avs_waitrequest;
   assign wmerge = be_merge(rd_mux(avs_address), avs_writedata,
      avs_byteenable);

   // one wait cycle per access; data and writes land on the low cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            // R10 uploaded table cannot be read back
            avs_readdata <= rd_mux(avs_address);
         end
      end
   end

   // mode and arithmetic settings
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctrl <= `LPP_CTRL_RST;
         black <= '0;
         gain_r <= `LPP_DGAIN_RST;
         gain_g <= `LPP_DGAIN_RST;
         gain_b <= `LPP_DGAIN_RST;
         lut_cmd <= 16'h0000;
         frame_lines <= `LPP_FRAME_RST;
      end else if (wr_go) begin
         if (avs_address == `LPP_REG_CTRL) begin
            ctrl <= {20'h0_0000, wmerge[11:0]};
         end else if (avs_address == `LPP_REG_BLACK) begin
            black <= wmerge[12:0];
         end else if (avs_address == `LPP_REG_GAIN_R) begin
            gain_r <= wmerge[15:0];
         end else if (avs_address == `LPP_REG_GAIN_G) begin
            gain_g <= wmerge[15:0];
         end else if (avs_address == `LPP_REG_GAIN_B) begin
            gain_b <= wmerge[15:0];
         end else if (avs_address == `LPP_REG_LUT_CMD) begin
            lut_cmd <= {wmerge[15:8], 6'h00, wmerge[1:0]};
         end else if (avs_address == `LPP_REG_FRAME) begin
            frame_lines <= wmerge[15:0];
         end
      end
   end

   // coefficient pointer, steps one column per data write
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ffc_addr <= 19'h0_0000;
      end else if (wr_go && avs_address == `LPP_REG_FFC_ADDR) begin
         ffc_addr <= wmerge[18:0];
      end else if (wr_go && avs_address == `LPP_REG_FFC_DATA) begin
         ffc_addr[COLW-1:0] <= ffc_addr[COLW-1:0] + 1'b1;
      end
   end

   // coefficient store; the host sends offsets then gains
   always_ff @(posedge clk_sys) begin
      if (wr_go && avs_address == `LPP_REG_FFC_DATA) begin
         // R17 coefficients are whole 16-bit words
         if (ffc_addr[`LPP_FFCA_GAIN]) begin
            // R14 gain half of the column pair
            ffc_gain[ffc_addr[`LPP_FFCA_SET]][ffc_addr[COLW-1:0]] <=
               wmerge[15:0];
         end else begin
            // R18 offset half comes first from the host
            ffc_off[ffc_addr[`LPP_FFCA_SET]][ffc_addr[COLW-1:0]] <=
               wmerge[15:0];
         end
      end
   end

   // table pointer; writes refused while the fill engine owns the table
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         lut_addr <= 12'h000;
      end else if (wr_go && avs_address == `LPP_REG_LUT_ADDR) begin
         lut_addr <= wmerge[11:0];
      end else if (wr_go && avs_address == `LPP_REG_LUT_DATA &&
            !fill_busy) begin
         lut_addr <= lut_addr + 12'h001;
      end
   end

   // R12 gamma curve or R08 neutral entry, narrowed for 8-bit output
   always_comb begin
      fill_val = fill_gamma ?
         gamma_entry(fill_idx, lut_cmd[`LPP_CMD_STRENGTH]) : fill_idx;
      if (out8) begin
         fill_val = {4'h0, fill_val[11:4]};
      end
   end

   // fill engine; reset starts a neutral fill of bank zero
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         fill_state <= lpp_pkg::LPP_FILL_RUN;
         fill_idx <= 12'h000;
         fill_gamma <= 1'b0;
      end else begin
         case (fill_state)
            lpp_pkg::LPP_FILL_IDLE: begin
               if (wr_go && avs_address == `LPP_REG_LUT_CMD &&
                     (wmerge[`LPP_CMD_NEUTRAL] || wmerge[`LPP_CMD_GAMMA])) begin
                  fill_state <= lpp_pkg::LPP_FILL_RUN;
                  fill_idx <= 12'h000;
                  fill_gamma <= wmerge[`LPP_CMD_GAMMA];
               end
            end
            lpp_pkg::LPP_FILL_RUN: begin
               fill_idx <= fill_idx + 12'h001;
               if (fill_idx == `LPP_PIX_MAX) begin
                  fill_state <= lpp_pkg::LPP_FILL_IDLE;
               end
            end
            default: begin
               fill_state <= lpp_pkg::LPP_FILL_IDLE;
            end
         endcase
      end
   end

   // R09 entries from a curve, single writes or a streamed file
   always_ff @(posedge clk_sys) begin
      if (fill_busy) begin
         // R11 table kept in the active configuration bank
         lut_mem[cfg_set][fill_idx] <= fill_val;
      end else if (wr_go && avs_address == `LPP_REG_LUT_DATA) begin
         lut_mem[cfg_set][lut_addr] <= wmerge[11:0];
      end
   end

   // column and line parity of the incoming pixel
   assign cur_col = in_sol ? '0 : col_cnt;
   assign cur_par = in_sol ? !line_par : line_par;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         col_cnt <= '0;
         line_par <= 1'b1;
      end else if (in_valid) begin
         col_cnt <= cur_col + 1'b1;
         line_par <= cur_par;
      end
   end

   // stage a: register pixel and fetch its column coefficients
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         a_valid <= 1'b0;
         a_sol <= 1'b0;
         a_par <= 1'b0;
         a_pix <= 12'h000;
         a_col <= '0;
         a_off <= 16'h0000;
         a_gain <= `LPP_FFC_GAIN_UNITY;
      end else begin
         a_valid <= in_valid;
         a_sol <= in_sol;
         a_par <= cur_par;
         a_pix <= in_data;
         a_col <= cur_col;
         // R16 coefficient set chosen by software
         a_off <= ffc_en ? ffc_off[ffc_set][cur_col] : 16'h0000;
         a_gain <= ffc_en ? ffc_gain[ffc_set][cur_col] :
            `LPP_FFC_GAIN_UNITY;
      end
   end

   // R02 colour mosaic r g / g b picks the gain; mono uses green
   always_comb begin
      dgain_sel = gain_g;
      if (COLOR && !a_col[0] && !a_par) begin
         dgain_sel = gain_r;
      end else if (COLOR && a_col[0] && a_par) begin
         dgain_sel = gain_b;
      end
   end

   // R20 saturating arithmetic lives in the sub block
   lpp_pix_arith #(
      .TAGW(COLW + 1)
   ) u_arith (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_valid(a_valid),
      .in_pix(a_pix),
      .in_off(a_off),
      .in_gain(a_gain),
      .in_dgain(dgain_sel),
      .in_black(black),
      .in_tag({a_sol, a_col}),
      .out_valid(b_valid),
      .out_pix(b_pix),
      .out_tag({b_sol, b_col})
   );

   // R03 R06 binning only on mono builds without super resolution
   always_comb begin
      hsh = (COLOR || SUPER_RES) ? 2'h0 : bin_shift(ctrl[`LPP_CTRL_BIN_H]);
      vsh = (COLOR || SUPER_RES) ? 2'h0 : bin_shift(ctrl[`LPP_CTRL_BIN_V]);
      hlast = 2'((3'h1 << hsh) - 3'h1);
      vlast = 2'((3'h1 << vsh) - 3'h1);
      cur_h = b_sol ? 2'h0 : hcnt;
      cur_v = b_sol ? ((vline >= vlast) ? 2'h0 : vline + 2'h1) : vline;
      hsum = ((cur_h == 2'h0) ? 14'h0000 : hacc) + {2'h0, b_pix};
      bcol = b_col >> hsh;
      // R04 partial sums carried across successive lines
      vsum = ((cur_v == 2'h0) ? 16'h0000 : vbuf[bcol]) + {2'h0, hsum};
      emit = b_valid && cur_h == hlast && cur_v == vlast;
   end

   // group counters; a mid-line mode change can misalign groups for the rest of the line, until a line start clears hcnt
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         hcnt <= 2'h0;
         vline <= 2'h3;
         hacc <= 14'h0000;
         sol_pend <= 1'b0;
      end else if (b_valid) begin
         hcnt <= (cur_h == hlast) ? 2'h0 : cur_h + 2'h1;
         vline <= cur_v;
         hacc <= hsum;
         // set wins: a new line start beats the clear by emission
         sol_pend <= b_sol || (sol_pend && !emit);
      end
   end

   // park column sums until the last line of the group
   always_ff @(posedge clk_sys) begin
      if (b_valid && cur_h == hlast && cur_v != vlast) begin
         vbuf[bcol] <= vsum;
      end
   end

   // stage e: binned pixel out of the group
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         e_valid <= 1'b0;
         e_sol <= 1'b0;
         e_sum <= 16'h0000;
      end else begin
         e_valid <= emit;
         e_sol <= emit && (sol_pend || b_sol);
         e_sum <= vsum;
      end
   end

   // R05 average by shifting, or clamp the plain sum
   // shift sum widened: 4x by 4x needs a shift of four, not two bits
   assign e_pix = bin_sum ? lpp_pkg::lpp_sat12($signed({18'h0_0000, e_sum}))
      : 12'(e_sum >> (3'(hsh) + 3'(vsh)));

   // output stage: table lookup or direct, 12-bit or top 8 bits
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         out_valid <= 1'b0;
         out_sol <= 1'b0;
         out_data <= 12'h000;
      end else begin
         out_valid <= e_valid;
         out_sol <= e_sol;
         if (lut_on) begin
            out_data <= lut_mem[cfg_set][e_pix];
         end else begin
            // R07 output width chosen at the last stage
            out_data <= out8 ? {4'h0, e_pix[11:4]} : e_pix;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence bus_req_s;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   bus_answer_a: assert property (
      bus_req_s |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not a single low cycle");
   lut_noread_a: assert property ( // R10
      bus_req_s and avs_read && avs_address == `LPP_REG_LUT_DATA
      |=> avs_readdata == 32'h0000_0000)
      else $error("table data read back");
   neutral_fill_a: assert property ( // R08
      fill_busy && !fill_gamma && out8
      |-> fill_val == {4'h0, fill_idx[11:4]})
      else $error("neutral entry not index over sixteen");
   lut_bypass_a: assert property ( // R13
      e_valid && !lut_on && !out8 |=> out_data == $past(e_pix))
      else $error("bypass path altered the pixel");
   vbin_hold_a: assert property ( // R04
      b_valid && cur_v != vlast |=> !e_valid ##1 !out_valid)
      else $error("pixel emitted before vertical group done");
   gain_pick_a: assert property ( // R02
      COLOR && a_valid && !a_col[0] && !a_par |-> dgain_sel == gain_r)
      else $error("red site did not use red gain");
endmodule : lpp_chain

// ---- core/lpp_defs.svh ----
`ifndef LPP_DEFS_SVH
`define LPP_DEFS_SVH
// Notes on behaviour
// R01: signed black level added to pixels, saturating
// R02: multiplicative digital gain, separate red green blue
// R03: mono binning 2x or 4x, h and v independent
// R04: vertical binning over lines, height reduced
// R05: binning mode selects average or sum
// R06: binning digital only; absent on super resolution
// R07: 12-bit internal path, 8 or 12-bit output
// R08: neutral 8-bit table maps index/16
// R09: table from gamma, single entries or file
// R10: uploaded table accepted but never read back
// R11: table banked with user configuration set
// R12: gamma below unity lifts, above suppresses lows
// R13: super resolution variant bypasses the table
// R14: offset and gain coefficient per column
// R15: subtract column offset then multiply column gain
// R16: several selectable coefficient memory sets
// R17: coefficients are 16-bit, valid both widths
// R18: host stores offsets upper half, gains lower; code puts offsets at bit 16 clear, gains at bit 16 set
// R19: host leaves other features alone during calibration
// R20: every arithmetic stage saturates, never wraps
`define LPP_REG_CTRL 8'h00
`define LPP_REG_BLACK 8'h04
`define LPP_REG_GAIN_R 8'h08
`define LPP_REG_GAIN_G 8'h0c
`define LPP_REG_GAIN_B 8'h10
`define LPP_REG_FFC_ADDR 8'h14
`define LPP_REG_FFC_DATA 8'h18
`define LPP_REG_LUT_ADDR 8'h1c
`define LPP_REG_LUT_DATA 8'h20
`define LPP_REG_LUT_CMD 8'h24
`define LPP_REG_STATUS 8'h28
`define LPP_REG_FRAME 8'h2c
`define LPP_REG_BINNED 8'h30
`define LPP_CTRL_FFC_EN 0
`define LPP_CTRL_LUT_EN 1
`define LPP_CTRL_BIN_H 3:2
`define LPP_CTRL_BIN_V 5:4
`define LPP_CTRL_BIN_SUM 6
`define LPP_CTRL_OUT8 7
`define LPP_CTRL_FFC_SET 9:8
`define LPP_CTRL_CFG_SET 11:10
`define LPP_CMD_NEUTRAL 0
`define LPP_CMD_GAMMA 1
`define LPP_CMD_STRENGTH 15:8
`define LPP_FFCA_GAIN 16
`define LPP_FFCA_SET 18:17
`define LPP_CTRL_RST 32'h0000_0000
`define LPP_DGAIN_RST 16'h0100
`define LPP_FFC_GAIN_UNITY 16'h1000
`define LPP_FFC_GAIN_SHIFT 12
`define LPP_DGAIN_SHIFT 8
`define LPP_GAMMA_SHIFT 19
`define LPP_FRAME_RST 16'h0400
`define LPP_PIX_MAX 12'hfff
`endif

// ---- core/lpp_pkg.sv ----
package lpp_pkg;
   // 12-bit internal pixel
   typedef logic [11:0] lpp_pix_t;
   // lut fill engine states
   typedef enum logic [1:0] {
      LPP_FILL_IDLE = 2'b00,
      LPP_FILL_RUN = 2'b01
   } lpp_fill_state_t;
   // clamp a wide signed value into 0..4095
   function automatic lpp_pix_t lpp_sat12(input logic signed [33:0] v);
      if (v < 34'sh0_0000) begin
         return 12'h000;
      end else if (v > 34'sh0_0fff) begin
         return 12'hfff;
      end
      return v[11:0];
   endfunction : lpp_sat12
endpackage : lpp_pkg

// ---- core/lpp_pix_arith.sv ----
`timescale 1ns/1ps
`include "lpp_defs.svh"
module lpp_pix_arith #(
   parameter int TAGW = 13  // sideband carried alongside the pixel
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic in_valid,
   input wire logic [11:0] in_pix,
   input wire logic [15:0] in_off,
   input wire logic [15:0] in_gain,
   input wire logic [15:0] in_dgain,
   input wire logic signed [12:0] in_black,
   input wire logic [TAGW-1:0] in_tag,
   output logic out_valid,
   output logic [11:0] out_pix,
   output logic [TAGW-1:0] out_tag
);
   logic [2:0] vld;  // stage valids
   logic [TAGW-1:0] t1, t2, t3;  // tag pipe
   logic [11:0] d1, p2, p3;  // stage results
   logic [15:0] g1, dg1, dg2;  // aligned gains
   logic signed [12:0] bk1, bk2, bk3;  // aligned black level
   logic [27:0] m2, m3;  // raw products, never truncated
   logic signed [33:0] s1, s4;  // signed sums before clamp

   // products and sums sized so no bit is lost before the clamp
   always_comb begin
      m2 = d1 * g1;
      m3 = p2 * dg2;
      s1 = $signed({{22{1'b0}}, in_pix}) - $signed({{18{1'b0}}, in_off});
      s4 = $signed({{22{1'b0}}, p3}) + $signed({{21{bk3[12]}}, bk3});
   end

   // valid and tag travel four stages with the data
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         vld <= 3'h0;
         out_valid <= 1'b0;
      end else begin
         vld <= {vld[1:0], in_valid};
         out_valid <= vld[2];
      end
   end

   // arithmetic pipe: offset, column gain, digital gain, black level
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         t1 <= '0;
         t2 <= '0;
         t3 <= '0;
         out_tag <= '0;
         d1 <= 12'h000;
         p2 <= 12'h000;
         p3 <= 12'h000;
         out_pix <= 12'h000;
         g1 <= 16'h0000;
         dg1 <= 16'h0000;
         dg2 <= 16'h0000;
         bk1 <= '0;
         bk2 <= '0;
         bk3 <= '0;
      end else begin
         t1 <= in_tag;
         t2 <= t1;
         t3 <= t2;
         out_tag <= t3;
         // R15 offset subtracted first
         d1 <= lpp_pkg::lpp_sat12(s1);
         g1 <= in_gain;
         dg1 <= in_dgain;
         bk1 <= in_black;
         // R15 then column gain applied
         p2 <= lpp_pkg::lpp_sat12(
            $signed({6'h00, m2 >> `LPP_FFC_GAIN_SHIFT}));
         dg2 <= dg1;
         bk2 <= bk1;
         // R02 digital gain multiply
         p3 <= lpp_pkg::lpp_sat12(
            $signed({6'h00, m3 >> `LPP_DGAIN_SHIFT}));
         bk3 <= bk2;
         // R01 signed black offset, clamped
         out_pix <= lpp_pkg::lpp_sat12(s4);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   ffc_pass_a: assert property ( // R15
      in_valid && in_off == 16'h0000 && in_gain == `LPP_FFC_GAIN_UNITY &&
      in_dgain == `LPP_DGAIN_RST && in_black == 13'sh0000
      |-> ##4 out_valid && out_pix == $past(in_pix, 4))
      else $error("unity chain did not pass pixel through");
   floor_zero_a: assert property ( // R20
      in_valid && {4'h0, in_pix} < in_off && in_black <= 13'sh0000
      |-> ##4 out_pix == 12'h000)
      else $error("underflow did not clamp to zero");
   black_add_a: assert property ( // R01
      vld[2] && p3 == 12'h000 && bk3 > 13'sh0000
      |=> out_pix == $past(bk3[11:0]))
      else $error("black level not added to dark pixel");
endmodule : lpp_pix_arith

// ---- verif/lpp_sensor_model.sv ----
`timescale 1ns/1ps
// sensor readout side: bursts of pixels, one per clock, no backpressure
module lpp_sensor_model (
   input wire logic clk_sys,
   input wire logic start,
   input wire logic [11:0] first,
   input wire logic [11:0] step,
   input wire logic [2:0] count,
   output logic in_valid = 1'b0,
   output logic in_sol = 1'b0,
   output logic [11:0] in_data = 12'h000
);
   logic [2:0] left = 3'h0; // pixels still to send
   always @(posedge clk_sys) begin
      if (start) begin
         in_valid <= 1'b1;
         in_sol <= 1'b1;
         in_data <= first;
         left <= count - 3'h1;
      end else if (in_valid && left != 3'h0) begin
         in_sol <= 1'b0;
         in_data <= in_data + step;
         left <= left - 3'h1;
      end else begin
         // idle: data toggles so a stale value never looks valid
         in_valid <= 1'b0;
         in_sol <= 1'b0;
         in_data <= ~in_data;
      end
   end
endmodule : lpp_sensor_model

// ---- verif/lpp_chain_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
 $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module lpp_chain_tb;
   typedef struct packed {
      logic [15:0] blk; // black level word
      logic [15:0] gn; // green gain word
      logic [11:0] pix; // raw input
      logic [11:0] want; // expected output
   } lpp_row_t;
   lpp_row_t rows [7] = '{'{16'h0000, 16'h0100, 12'h123, 12'h123},
      '{16'h0010, 16'h0100, 12'h100, 12'h110},
      '{16'h1ff0, 16'h0100, 12'h100, 12'h0f0},
      '{16'h1fe0, 16'h0100, 12'h010, 12'h000},
      '{16'h0000, 16'h0200, 12'h900, 12'hfff},
      '{16'h0000, 16'h0180, 12'h100, 12'h180},
      '{16'h0020, 16'h0100, 12'h000, 12'h020}};
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, in_valid, in_sol, out_valid, out_sol;
   logic [11:0] in_data, out_data;
   logic [11:0] p_first = 12'h000;
   logic go = 1'b0;
   logic [2:0] p_cnt = 3'h1;
   int fails = 0;
   int samples_checked = 0;
   lpp_chain #(.COLS(16)) dut_u (.clk_sys(clk_sys), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .in_valid(in_valid), .in_sol(in_sol), .in_data(in_data),
      .out_valid(out_valid), .out_sol(out_sol), .out_data(out_data));
   lpp_sensor_model sensor_u (.clk_sys(clk_sys), .start(go), .first(p_first),
      .step(12'h100), .count(p_cnt), .in_valid(in_valid), .in_sol(in_sol),
      .in_data(in_data));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   // one avalon access, held until waitrequest is seen low
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      // no cycle limit here: a hung slave is left to the watchdog
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   // a short burst from column 0, then one expected output pixel
   task pix(input logic [11:0] f, input logic [2:0] n, input logic [11:0] e);
      @(posedge clk_sys);
      go <= 1'b1;
      p_first <= f;
      p_cnt <= n;
      @(posedge clk_sys);
      go <= 1'b0;
      for (int k = 0; k < 30; k++) begin
         @(negedge clk_sys);
         if (out_valid === 1'b1) break;
      end
      `CHK(out_valid, 1'b1)
      `CHK(out_data, e)
   endtask : pix
   // table fill command, bounded wait on busy, then one pixel
   task pixel_lookup_table(input logic [31:0] c, input logic [11:0] f, input logic [11:0] e);
      bus(1'b1, 8'h24, c);
      for (int k = 0; k < 3000; k++) begin
         bus(1'b0, 8'h28, 32'h0000_0000);
         if (q[0] === 1'b0) break;
      end
      `CHK(q[0], 1'b0)
      pix(f, 3'h1, e);
   endtask : pixel_lookup_table
   task complete_run;
      $display("checked %0d failed %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   initial begin
      repeat (16) @(posedge clk_sys);
      `CHK(avs_waitrequest, 1'b1)
      `CHK(out_valid, 1'b0)
      reset <= 1'b0;
      bus(1'b0, 8'h2c, 32'h0000_0000);
      `CHK(q, 32'h0000_0400)
      pixel_lookup_table(32'h0000_0000, 12'h123, 12'h123);
      foreach (rows[i]) begin
         bus(1'b1, 8'h04, {16'h0000, rows[i].blk});
         bus(1'b1, 8'h0c, {16'h0000, rows[i].gn});
         pix(rows[i].pix, 3'h1, rows[i].want);
      end
      bus(1'b1, 8'h04, 32'h0000_0000);
      bus(1'b1, 8'h0c, 32'h0000_0100);
      // column 0 coefficients: offset 0x10, gain 2.0
      // offset then gain
      bus(1'b1, 8'h14, 32'h0000_0000);
      bus(1'b1, 8'h18, 32'h0000_0010);
      bus(1'b1, 8'h14, 32'h0001_0000);
      bus(1'b1, 8'h18, 32'h0000_2000);
      bus(1'b1, 8'h00, 32'h0000_0001);
      pix(12'h110, 3'h1, 12'h200);
      pix(12'h008, 3'h1, 12'h000);
      bus(1'b1, 8'h00, 32'h0000_0044);
      pix(12'h100, 3'h2, 12'h300);
      bus(1'b1, 8'h00, 32'h0000_0004);
      pix(12'h100, 3'h2, 12'h180);
      bus(1'b1, 8'h00, 32'h0000_0020);
      bus(1'b0, 8'h30, 32'h0000_0000);
      `CHK(q, 32'h0000_0100)
      bus(1'b1, 8'h00, 32'h0000_0082);
      pixel_lookup_table(32'h0000_0001, 12'h4ff, 12'h04f);
      pixel_lookup_table(32'h0000_0001, 12'hfff, 12'h0ff);
      pixel_lookup_table(32'h0000_4002, 12'h400, 12'h057);
      pixel_lookup_table(32'h0000_c002, 12'h400, 12'h028);
      bus(1'b0, 8'h20, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
      bus(1'b1, 8'h3c, 32'h0000_ffff);
      bus(1'b0, 8'h3c, 32'h0000_0000);
      `CHK(q, 32'h0000_0000)
      // mid-run reset, then 2x vertical sum over two lines
      reset <= 1'b1;
      repeat (2) @(posedge clk_sys);
      `CHK(out_data, 12'h000)
      `CHK(avs_waitrequest, 1'b1)
      reset <= 1'b0;
      bus(1'b1, 8'h00, 32'h0000_0050);
      go <= 1'b1;
      p_first <= 12'h100;
      @(posedge clk_sys);
      go <= 1'b0;
      pix(12'h200, 3'h1, 12'h300);
      complete_run();
   end
   initial begin
      #400000;
      fails++;
      complete_run();
   end
endmodule : lpp_chain_tb
